// [core/artimer_pkg.sv]
package artimer_pkg;
  localparam logic [7:0] mode_ctrl_addr = 8'hd5;
  localparam logic [7:0] flag_status_addr = 8'hd6;
  localparam logic [7:0] clk_edge_cfg_addr = 8'hd7;
  localparam logic [7:0] reload_addr = 8'hd9;
  localparam logic [7:0] compare_addr = 8'hda;
  localparam logic [7:0] live_load_addr = 8'hdb;
  // mode control fields
  localparam int load_bit = 7;
  localparam int count_en_bit = 6;
  localparam int wave_oe_bit = 5;
  localparam int edge_ie_bit = 4;
  localparam int match_ie_bit = 3;
  localparam int wrap_ie_bit = 2;
  localparam int mode_lsb = 0;
  // status fields
  localparam int edge_flag_bit = 2;
  localparam int match_flag_bit = 1;
  localparam int wrap_flag_bit = 0;
  // clock/edge config fields
  localparam int div_lsb = 5;
  localparam int reserved_cfg_bit = 4;
  localparam int edge_pol_bit = 3;
  localparam int edge_en_bit = 2;
  localparam int src_lsb = 0;
  // reset values, counter top and div3 last count
  localparam logic [6:0] mode_ctrl_rst = 7'h00;
  localparam logic [7:0] cfg_rst = 8'h00;
  localparam logic [7:0] reload_rst = 8'h00;
  localparam logic [7:0] compare_rst = 8'h00;
  localparam logic [7:0] counter_rst = 8'h00;
  localparam logic [7:0] counter_max = 8'hff;
  localparam logic [1:0] div3_last = 2'h2;
  // mode and source codes
  localparam logic [1:0] mode_autoreload = 2'h0;
  localparam logic [1:0] mode_capture = 2'h1;
  localparam logic [1:0] mode_capture_rst = 2'h2;
  localparam logic [1:0] mode_edge_load = 2'h3;
  localparam logic [1:0] src_internal = 2'h0;
  localparam logic [1:0] src_div3 = 2'h1;
  localparam logic [1:0] src_pin = 2'h2;
endpackage

// [core/prescale_if.sv]
`timescale 1ns/10ps
interface prescale_if;
  logic [1:0] clock_source_select;
  logic [2:0] divider_select;
  logic count_enable;
  logic clear;
  logic pin_pulse;
  logic tick;
  modport core (output clock_source_select, output divider_select, output count_enable,
                output clear, output pin_pulse, input tick);
  modport scaler (input clock_source_select, input divider_select, input count_enable,
                  input clear, input pin_pulse, output tick);
endinterface

// [core/clock_prescaler.sv]
`timescale 1ns/10ps
module clock_prescaler (
  input wire logic sys_clk,
  input wire logic rstn,
  prescale_if.scaler ps
);
  logic [1:0] div3_q;
  logic [6:0] prescaler_count_q;
  logic src_tick;
  logic [7:0] full_mask;

  always_comb begin
    case (ps.clock_source_select)
      artimer_pkg::src_internal: src_tick = 1'b1;
      artimer_pkg::src_div3: src_tick = (div3_q == artimer_pkg::div3_last);
      artimer_pkg::src_pin: src_tick = ps.pin_pulse;
      default: src_tick = 1'b0;
    endcase
  end

  // ratio 2^n: tick when the low n bits roll over
  assign full_mask = (8'h01 << ps.divider_select) - 8'h01;
  // clear left out: the core decides clear from its own loads, not from tick
  assign ps.tick = ps.count_enable && src_tick &&
                   ((prescaler_count_q & full_mask[6:0]) == full_mask[6:0]);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div3_q <= 2'h0;
    end else if (ps.count_enable) begin
      div3_q <= (div3_q == artimer_pkg::div3_last) ? 2'h0 : div3_q + 2'h1;
    end
  end

  // divider select only steers the mask, never touches the count
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prescaler_count_q <= 7'h00;
    end else if (ps.clear) begin
      prescaler_count_q <= 7'h00;
    end else if (ps.count_enable && src_tick) begin
      prescaler_count_q <= prescaler_count_q + 7'h01;
    end
  end
endmodule // clock_prescaler

// [core/autoreload_pwm_timer.sv]
`timescale 1ns/10ps
module autoreload_pwm_timer (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic timer_input_pin,
  output logic timer_wave_pin,
  output logic edge_irq,
  output logic match_irq,
  output logic wrap_irq
);
  prescale_if psc ();

  logic [6:0] mode_ctrl_q;
  logic [7:0] cfg_q;
  logic [7:0] reload_q;
  logic [7:0] compare_q;
  logic [7:0] live_load_q;
  logic [7:0] main_counter_q;
  logic [7:0] main_counter_d;
  logic edge_flag_q;
  logic match_flag_q;
  logic wrap_flag_q;
  logic wave_q;
  logic wave_d;
  logic [7:0] rdata_q;
  logic wave_pin_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;

  logic count_enable;
  logic wave_output_enable;
  logic edge_irq_enable;
  logic match_irq_enable;
  logic wrap_irq_enable;
  logic [1:0] mode_sel;
  logic wr_mode;
  logic wr_status;
  logic wr_cfg;
  logic wr_reload;
  logic wr_compare;
  logic wr_live;
  logic counter_load_strobe;
  logic rewrite;
  logic pin_rise;
  logic pin_fall;
  logic edge_evt;
  logic capture_evt;
  logic cpu_load;
  logic wrap_evt;
  logic match_evt;
  logic cnt_update;

  clock_prescaler clock_prescaler_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ps(psc)
  );

  ////////////////////////////////////////////////////////////////////////
  // field decode

  assign count_enable = mode_ctrl_q[artimer_pkg::count_en_bit];
  assign wave_output_enable = mode_ctrl_q[artimer_pkg::wave_oe_bit];
  assign edge_irq_enable = mode_ctrl_q[artimer_pkg::edge_ie_bit];
  assign match_irq_enable = mode_ctrl_q[artimer_pkg::match_ie_bit];
  assign wrap_irq_enable = mode_ctrl_q[artimer_pkg::wrap_ie_bit];
  assign mode_sel = mode_ctrl_q[artimer_pkg::mode_lsb +: 2];

  assign wr_mode = reg_wr && (reg_addr == artimer_pkg::mode_ctrl_addr);
  assign wr_status = reg_wr && (reg_addr == artimer_pkg::flag_status_addr);
  assign wr_cfg = reg_wr && (reg_addr == artimer_pkg::clk_edge_cfg_addr);
  assign wr_reload = reg_wr && (reg_addr == artimer_pkg::reload_addr);
  assign wr_compare = reg_wr && (reg_addr == artimer_pkg::compare_addr);
  assign wr_live = reg_wr && (reg_addr == artimer_pkg::live_load_addr);

  assign counter_load_strobe = wr_mode && reg_wdata[artimer_pkg::load_bit];
  // same-value rewrite while the wave runs restarts the period
  assign rewrite = wr_mode && !reg_wdata[artimer_pkg::load_bit] &&
                   (reg_wdata[6:0] == mode_ctrl_q) && count_enable &&
                   wave_output_enable;

  ////////////////////////////////////////////////////////////////////////
  // input pin: two-flop synchroniser, then edge detect on stage two

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= timer_input_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_rise = pin_s2_q && !pin_s3_q;
  assign pin_fall = !pin_s2_q && pin_s3_q;
  assign edge_evt = cfg_q[artimer_pkg::edge_en_bit] &&
                    (cfg_q[artimer_pkg::edge_pol_bit] ? pin_fall : pin_rise);
  assign capture_evt = edge_evt &&
                       ((mode_sel == artimer_pkg::mode_capture) ||
                        (mode_sel == artimer_pkg::mode_capture_rst));

  ////////////////////////////////////////////////////////////////////////
  // prescaler hookup

  assign psc.clock_source_select = cfg_q[artimer_pkg::src_lsb +: 2];
  assign psc.divider_select = cfg_q[artimer_pkg::div_lsb +: 3];
  assign psc.count_enable = count_enable;
  assign psc.pin_pulse = pin_rise;

  ////////////////////////////////////////////////////////////////////////
  // counter next state; cpu loads win over edge events, edges over ticks

  assign cpu_load = counter_load_strobe || wr_live || rewrite;

  always_comb begin
    main_counter_d = main_counter_q;
    wrap_evt = 1'b0;
    cnt_update = 1'b1;
    psc.clear = 1'b1;
    if (wr_live) begin
      main_counter_d = reg_wdata;
    end else if (counter_load_strobe || rewrite) begin
      main_counter_d = reload_q;
    end else if (edge_evt && mode_sel == artimer_pkg::mode_capture_rst) begin
      main_counter_d = artimer_pkg::counter_rst;
    end else if (edge_evt && mode_sel == artimer_pkg::mode_edge_load) begin
      main_counter_d = reload_q;
    end else begin
      psc.clear = 1'b0;
      if (psc.tick) begin
        if (main_counter_q == artimer_pkg::counter_max) begin
          wrap_evt = 1'b1;
          // free-running in the capture modes: the reload register holds captures
          main_counter_d = (mode_sel == artimer_pkg::mode_autoreload) ?
                           reload_q : artimer_pkg::counter_rst;
        end else begin
          main_counter_d = main_counter_q + 8'h01;
        end
      end else begin
        cnt_update = 1'b0;
      end
    end
  end

  assign match_evt = cnt_update && (main_counter_d == compare_q);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      main_counter_q <= artimer_pkg::counter_rst;
    end else begin
      main_counter_q <= main_counter_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wave: set on wrap, cleared on match; rewrite freezes the level

  always_comb begin
    wave_d = wave_q;
    if (rewrite) begin
      wave_d = wave_q;
    end else if (match_evt) begin
      wave_d = 1'b0;
    end else if (wrap_evt) begin
      wave_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wave_q <= 1'b0;
      wave_pin_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
      wave_pin_q <= wave_d && wave_output_enable;
    end
  end

  assign timer_wave_pin = wave_pin_q;

  ////////////////////////////////////////////////////////////////////////
  // status flags: a hardware set in the clearing cycle wins

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      edge_flag_q <= 1'b0;
      match_flag_q <= 1'b0;
      wrap_flag_q <= 1'b0;
    end else begin
      edge_flag_q <= edge_evt ||
        (edge_flag_q && !(wr_status && !reg_wdata[artimer_pkg::edge_flag_bit]));
      match_flag_q <= match_evt ||
        (match_flag_q && !(wr_status && !reg_wdata[artimer_pkg::match_flag_bit]));
      wrap_flag_q <= wrap_evt ||
        (wrap_flag_q && !(wr_status && !reg_wdata[artimer_pkg::wrap_flag_bit]));
    end
  end

  assign edge_irq = edge_flag_q && edge_irq_enable;
  assign match_irq = match_flag_q && match_irq_enable;
  assign wrap_irq = wrap_flag_q && wrap_irq_enable;

  ////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_ctrl_q <= artimer_pkg::mode_ctrl_rst;
    end else if (wr_mode) begin
      mode_ctrl_q <= reg_wdata[6:0];
    end
  end

  // reserved config bit is forced low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= artimer_pkg::cfg_rst;
    end else if (wr_cfg) begin
      cfg_q <= reg_wdata & ~(8'h01 << artimer_pkg::reserved_cfg_bit);
    end
  end

  // a capture in the same cycle as a cpu write wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reload_q <= artimer_pkg::reload_rst;
    end else if (capture_evt) begin
      reload_q <= main_counter_q;
    end else if (wr_reload) begin
      reload_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      compare_q <= artimer_pkg::compare_rst;
    end else if (wr_compare) begin
      compare_q <= reg_wdata;
    end
  end

  // no reset on purpose: follows the counter only when it moves, so a reset keeps it
  always_ff @(posedge sys_clk) begin
    if (cnt_update) begin
      live_load_q <= main_counter_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: one cycle latency, unmapped reads zero

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        artimer_pkg::mode_ctrl_addr: rdata_q <= {1'b0, mode_ctrl_q};
        artimer_pkg::flag_status_addr: rdata_q <= {5'h00, edge_flag_q, match_flag_q,
                                                   wrap_flag_q};
        artimer_pkg::clk_edge_cfg_addr: rdata_q <= cfg_q;
        artimer_pkg::reload_addr: rdata_q <= reload_q;
        artimer_pkg::compare_addr: rdata_q <= compare_q;
        artimer_pkg::live_load_addr: rdata_q <= live_load_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence rewrite_s;
    rewrite && !wr_live;
  endsequence

  sequence tick_wrap_s;
    !cpu_load && !edge_evt && psc.tick && main_counter_q == artimer_pkg::counter_max;
  endsequence

  mode_reset_clear_a: assert property ($rose(rstn) |-> mode_ctrl_q == 7'h00)
    else $error("mode control not clear after reset");

  rewrite_restart_a: assert property (rewrite_s |=>
    main_counter_q == $past(reload_q) && wave_q == $past(wave_q))
    else $error("same-value rewrite did not restart with held level");

  load_bit_zero_a: assert property (reg_rd && reg_addr == artimer_pkg::mode_ctrl_addr
    |=> !reg_rdata[artimer_pkg::load_bit])
    else $error("load bit read back as one");

  load_strobe_a: assert property (counter_load_strobe && !wr_live
    |=> main_counter_q == $past(reload_q))
    else $error("load strobe did not copy reload value");

  stopped_hold_a: assert property (!count_enable && !cpu_load && !edge_evt
    |=> $stable(main_counter_q))
    else $error("counter moved while stopped");

  wave_gate_a: assert property (!wave_output_enable && !wr_mode |=> ##1 !timer_wave_pin)
    else $error("wave on pin while output disabled");

  irq_mask_a: assert property ((edge_irq == (edge_flag_q && edge_irq_enable)) &&
    (match_irq == (match_flag_q && match_irq_enable)) &&
    (wrap_irq == (wrap_flag_q && wrap_irq_enable)))
    else $error("interrupt request not flag and enable");

  flag_clear_a: assert property (wr_status && !reg_wdata[artimer_pkg::wrap_flag_bit]
    && !wrap_evt |=> !wrap_flag_q)
    else $error("wrap flag not cleared by zero write");

  edge_flag_set_a: assert property (edge_evt |=> edge_flag_q)
    else $error("edge flag missed an edge");

  match_set_a: assert property (match_evt |=> match_flag_q && !wave_q)
    else $error("match did not set flag and clear wave");

  wrap_reload_a: assert property ((tick_wrap_s and (mode_sel == artimer_pkg::mode_autoreload))
    |=> wrap_flag_q && main_counter_q == $past(reload_q))
    else $error("wrap did not reload and flag");

  capture_copy_a: assert property (capture_evt |=> reload_q == $past(main_counter_q))
    else $error("capture did not copy counter");

endmodule // autoreload_pwm_timer

// [testbench/timer_pin_model.sv]
`timescale 1ns/10ps
module timer_pin_model (
  input wire logic sys_clk,
  output logic timer_input_pin,
  input wire logic timer_wave_pin
);
  initial timer_input_pin = 1'b0;

  ////////////////////////////////////////////////////////////////
  // level held 8 cycles, well above the synchroniser minimum
  task automatic drive(input logic v);
    @(negedge sys_clk);
    timer_input_pin = v;
    repeat (8) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////
  // one whole wave cycle in sys_clk cycles; period -1 on timeout
  task automatic measure(output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    while (timer_wave_pin !== 1'b0 && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
    while (timer_wave_pin !== 1'b1 && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
    while (timer_wave_pin === 1'b1 && n < 9000) begin
      @(negedge sys_clk);
      n++;
      hi++;
    end
    per = hi;
    while (timer_wave_pin === 1'b0 && n < 9000) begin
      @(negedge sys_clk);
      n++;
      per++;
    end
    if (n >= 9000) begin
      per = -1;
    end
  endtask
endmodule // timer_pin_model

// [testbench/autoreload_pwm_timer_tb.sv]
`timescale 1ns/10ps
module autoreload_pwm_timer_tb;
  logic sys_clk;
  logic rstn;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic timer_input_pin;
  logic timer_wave_pin;
  logic edge_irq;
  logic match_irq;
  logic wrap_irq;
  int bad_count;
  int cmp_count;
  int hi;
  int per;
  logic [7:0] regs [6];

  autoreload_pwm_timer autoreload_pwm_timer_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .timer_input_pin(timer_input_pin),
    .timer_wave_pin(timer_wave_pin),
    .edge_irq(edge_irq),
    .match_irq(match_irq),
    .wrap_irq(wrap_irq)
  );

  timer_pin_model timer_pin_model_inst (
    .sys_clk(sys_clk),
    .timer_input_pin(timer_input_pin),
    .timer_wave_pin(timer_wave_pin)
  );

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // strobes rise and fall on separate falling edges, never twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string name);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    check(name, reg_rdata, e);
  endtask

  // reload f0, compare f8: 8 ticks high in a 16 tick period
  task automatic wave_run(input logic [7:0] cfg, input int exp_hi, input int exp_per);
    wr(8'hd7, cfg);
    wr(8'hd5, 8'hec);
    timer_pin_model_inst.measure(hi, per);
    if (per < 0) begin
      bad_count++;
      finish_test();
    end
    check("wave high time", hi, exp_hi);
    check("wave period", per, exp_per);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    bad_count = 0;
    cmp_count = 0;
    regs = '{8'hd5, 8'hd6, 8'hd7, 8'hd9, 8'hda, 8'hd8};
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    check("wave after reset", timer_wave_pin, 1'b0);
    check("irqs after reset", {edge_irq, match_irq, wrap_irq}, 3'h0);
    for (int i = 0; i < 6; i++) begin
      rchk(regs[i], 8'h00, "reset value");
    end
    wr(8'hd8, 8'hff);
    rchk(8'hd8, 8'h00, "unmapped");
    wr(8'hd7, 8'hff);
    rchk(8'hd7, 8'hef, "clock edge config");
    wr(8'hda, 8'ha5);
    rchk(8'hda, 8'ha5, "compare");
    wr(8'hd5, 8'hbf);
    rchk(8'hd5, 8'h3f, "mode control");
    wr(8'hd5, 8'h00);
    // auto-reload pwm across every divider code, then internal/3
    wr(8'hd9, 8'hf0);
    wr(8'hda, 8'hf8);
    for (int c = 0; c < 8; c++) begin
      wave_run({c[2:0], 5'h00}, 8 << c, 16 << c);
    end
    wave_run(8'h01, 24, 48);
    check("match and wrap irqs", {match_irq, wrap_irq}, 2'h3);
    // same-value rewrite four ticks into the high phase: high holds 8 ticks more
    repeat (11) @(negedge sys_clk);
    wr(8'hd5, 8'h6c);
    hi = 0;
    while (timer_wave_pin === 1'b1 && hi < 100) begin
      @(negedge sys_clk);
      hi++;
    end
    check("rewrite high time", hi, 23);
    wr(8'hd5, 8'h40);
    check("masked irqs", {edge_irq, match_irq, wrap_irq}, 3'h0);
    repeat (3) @(negedge sys_clk);
    hi = 0;
    repeat (300) begin
      @(negedge sys_clk);
      if (timer_wave_pin !== 1'b0) begin
        hi++;
      end
    end
    check("wave while disabled", hi, 0);
    wr(8'hd5, 8'h00);
    rchk(8'hd6, 8'h03, "flags");
    wr(8'hd6, 8'hfe);
    rchk(8'hd6, 8'h02, "flag clear");
    wr(8'hd6, 8'hff);
    rchk(8'hd6, 8'h02, "flag keep");
    wr(8'hd6, 8'h00);
    rchk(8'hd6, 8'h00, "flags cleared");
    // capture on a rising edge with the counter frozen at 33
    wr(8'hd9, 8'h33);
    wr(8'hd5, 8'h80);
    wr(8'hd9, 8'h55);
    wr(8'hd7, 8'h04);
    wr(8'hd5, 8'h11);
    timer_pin_model_inst.drive(1'b1);
    rchk(8'hd9, 8'h33, "capture");
    rchk(8'hd6, 8'h04, "edge flag");
    check("edge irq", edge_irq, 1'b1);
    // falling select, then detection off
    wr(8'hd6, 8'h00);
    wr(8'hd7, 8'h0c);
    timer_pin_model_inst.drive(1'b0);
    rchk(8'hd6, 8'h04, "falling edge");
    wr(8'hd6, 8'h00);
    timer_pin_model_inst.drive(1'b1);
    rchk(8'hd6, 8'h00, "rise ignored");
    wr(8'hd7, 8'h00);
    timer_pin_model_inst.drive(1'b0);
    timer_pin_model_inst.drive(1'b1);
    rchk(8'hd6, 8'h00, "detection off");
    // capture with reset
    wr(8'hd9, 8'h40);
    wr(8'hd5, 8'h80);
    wr(8'hd9, 8'h12);
    wr(8'hd7, 8'h04);
    wr(8'hd5, 8'h02);
    timer_pin_model_inst.drive(1'b0);
    timer_pin_model_inst.drive(1'b1);
    rchk(8'hd9, 8'h40, "capture before reset");
    rchk(8'hdb, 8'h00, "counter reset");
    // load on edge, counter stopped
    wr(8'hd9, 8'h77);
    wr(8'hd5, 8'h03);
    timer_pin_model_inst.drive(1'b0);
    timer_pin_model_inst.drive(1'b1);
    rchk(8'hdb, 8'h77, "edge load");
    repeat (20) @(negedge sys_clk);
    rchk(8'hdb, 8'h77, "frozen counter");
    wr(8'hdb, 8'h5a);
    rchk(8'hdb, 8'h5a, "live load");
    // reset in mid-run: load register keeps its value
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    check("wave after mid reset", timer_wave_pin, 1'b0);
    rchk(8'hd5, 8'h00, "mode after mid reset");
    rchk(8'hdb, 8'h5a, "load kept over reset");
    finish_test();
  end
endmodule // autoreload_pwm_timer_tb
